//--- logic/stdcc_map.svh
`ifndef STDCC_MAP_SVH
`define STDCC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------------------
`define STDCC_CTRL_OFS       8'h00
`define STDCC_STATUS_OFS     8'h04
`define STDCC_MASK_OFS       8'h08
`define STDCC_STATE_OFS      8'h0C
`define STDCC_POS_OFS        8'h10
`define STDCC_SPR_OFS        8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define STDCC_CTRL_CUR_LSB   0
`define STDCC_CTRL_RES_LSB   8
`define STDCC_IRQ_FAULT      0
`define STDCC_IRQ_SELFTEST   1
`define STDCC_IRQ_STANDSTILL 2
`define STDCC_SW_CUR_LSB     0
`define STDCC_SW_SEL         3
`define STDCC_SW_RES_LSB     4
`define STDCC_SW_RES_MODE    7

// ----------------------------------------------------------------------------
// Reset values and limits (currents in tenths of an ampere)
// ----------------------------------------------------------------------------
`define STDCC_CUR_RST        7'h05
`define STDCC_RES_RST        10'h001
`define STDCC_CUR_MIN        7'h05
`define STDCC_CUR_MAX        7'h52
`define STDCC_RES_MIN        10'h001
`define STDCC_RES_MAX        10'h200
`define STDCC_FULL_STEPS     17'h0_00C8
`define STDCC_RED_NUM        9'h003
`define STDCC_RED_DEN        9'h005

// ----------------------------------------------------------------------------
// Switch tables
// ----------------------------------------------------------------------------
`define STDCC_CUR_TABLE  {7'h52, 7'h48, 7'h3F, 7'h34, 7'h2D, 7'h20, 7'h16, 7'h00}
`define STDCC_SPR_BASE   17'h0_0190
`define STDCC_SPR_TABLE  {17'h0_61A8, 17'h0_4E20, 17'h0_2710, 17'h0_1F40, \
                          17'h0_1388, 17'h0_0FA0, 17'h0_07D0, 17'h0_03E8}

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define STDCC_CLK_HZ         40000000
`define STDCC_STANDSTILL_MS  400
`define STDCC_TAP_WINDOW_MS  1000
`define STDCC_MS_CYCLES(ms)  ((`STDCC_CLK_HZ / 1000) * (ms))

`endif

//--- logic/stdcc_pkg.sv
package stdcc_pkg;
`include "stdcc_map.svh"

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [0:0] {
      STDCC_TAP_IDLE = 1'b0,
      STDCC_TAP_ONE  = 1'b1
   } stdcc_tap_t;

   typedef struct packed {
      logic [6:0]  sw_cur;
      logic [9:0]  sw_res;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      stdcc_tap_t  tap;
      logic        step_d;
      logic        sel_d;
      logic        fault;
      logic        reduced;
      logic        energ;
      logic        dir;
      logic [15:0] pos;
      logic [6:0]  cur_out;
      logic [16:0] spr;
      logic        test_pulse;
      logic        alarm_oe;
      logic        red;
      logic        green;
      logic        irq;
      logic        dp_wr;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
      logic        hrdy;
   } stdcc_state_t;

endpackage

//--- logic/stdcc_timer.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Retriggerable delay: expired rises COUNT cycles after the last restart.
// ----------------------------------------------------------------------------
module stdcc_timer #(
   parameter int COUNT = 16
) (
   input  wire logic clk,      // System clock.
   input  wire logic rst,      // Asynchronous reset, active high.
   input  wire logic restart,  // Reload the delay.
   output logic      expired   // High once the delay has run out.
);
   localparam int W = $clog2(COUNT + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
   } stdcc_tmr_t;

   stdcc_tmr_t s_reg;
   stdcc_tmr_t s_next;

   if (COUNT < 1) begin : g_chk
      $error("stdcc_timer: COUNT must be at least one");
   end

   // Count down to zero; the timer starts expired so nothing waits after reset.
   always_comb begin
      s_next = s_reg;
      if (restart) begin
         s_next.cnt = W'(COUNT);
      end else if (s_reg.cnt != '0) begin
         s_next.cnt = s_reg.cnt - 1'b1;
      end
      s_next.done = (s_next.cnt == '0);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '{cnt: '0, done: 1'b1};
      end else begin
         s_reg <= s_next;
      end
   end

   assign expired = s_reg.done;
endmodule

//--- logic/stdcc_cfg_decode.sv
`timescale 1ns/1ps
`include "stdcc_map.svh"

// ----------------------------------------------------------------------------
// Switch bank decode into operating current and resolution.
// ----------------------------------------------------------------------------
module stdcc_cfg_decode
   import stdcc_pkg::*;
(
   input  wire logic [7:0]  switches,   // Switch bank, 1 = on.
   input  wire logic [6:0]  soft_cur,   // Software current, tenths of an ampere.
   input  wire logic [9:0]  soft_res,   // Software resolution, microsteps per step.
   output logic      [6:0]  cur_tenths, // Selected peak current.
   output logic      [16:0] steps_rev,  // Selected steps per revolution.
   output logic             cur_soft,   // Current comes from software.
   output logic             res_soft    // Resolution comes from software.
);
   localparam logic [7:0][6:0]  CUR_TAB = `STDCC_CUR_TABLE;
   localparam logic [7:0][16:0] SPR_TAB = `STDCC_SPR_TABLE;

   logic [2:0] cur_code;
   logic [2:0] res_idx;
   logic [6:0] cur_clamped;
   logic [9:0] res_clamped;

   // Off switches count as ones in the resolution index.
   always_comb begin
      cur_code    = switches[`STDCC_SW_CUR_LSB +: 3];
      res_idx     = ~switches[`STDCC_SW_RES_LSB +: 3];
      cur_soft    = (cur_code == 3'h0);
      res_soft    = switches[`STDCC_SW_RES_MODE] && (res_idx == 3'h0);
      cur_clamped = soft_cur;
      if (soft_cur < `STDCC_CUR_MIN) cur_clamped = `STDCC_CUR_MIN;
      if (soft_cur > `STDCC_CUR_MAX) cur_clamped = `STDCC_CUR_MAX;
      res_clamped = soft_res;
      if (soft_res < `STDCC_RES_MIN) res_clamped = `STDCC_RES_MIN;
      if (soft_res > `STDCC_RES_MAX) res_clamped = `STDCC_RES_MAX;
      cur_tenths  = cur_soft ? cur_clamped : CUR_TAB[cur_code];
      if (res_soft) begin
         steps_rev = 17'(res_clamped) * `STDCC_FULL_STEPS;
      end else if (switches[`STDCC_SW_RES_MODE]) begin
         steps_rev = `STDCC_SPR_BASE << (res_idx - 3'h1);
      end else begin
         steps_rev = SPR_TAB[res_idx];
      end
   end
endmodule

//--- logic/stdcc_top.sv
`timescale 1ns/1ps
`include "stdcc_map.svh"

module stdcc_top
   import stdcc_pkg::*;
#(
   parameter int STANDSTILL_CYCLES = `STDCC_MS_CYCLES(`STDCC_STANDSTILL_MS),
   parameter int TAP_WINDOW_CYCLES = `STDCC_MS_CYCLES(`STDCC_TAP_WINDOW_MS)
) (
   input  wire logic        clk,                  // 40 MHz system clock.
   input  wire logic        rst,                  // Power-on reset, asynchronous, high.
   // Bus slave.
   input  wire logic        hsel,                 // Slave select.
   input  wire logic [7:0]  haddr,                // Byte address.
   input  wire logic [1:0]  htrans,               // Transfer type.
   input  wire logic        hwrite,               // Write when high.
   input  wire logic [2:0]  hsize,                // Transfer size, word only.
   input  wire logic [31:0] hwdata,               // Write data.
   input  wire logic        hready,               // Bus ready.
   output logic             hreadyout,            // Slave ready.
   output logic             hresp,                // Always OKAY.
   output logic [31:0]      hrdata,               // Read data.
   // Controller and switches.
   input  wire logic        step_pulse_input,     // Step pulse, rising edge active.
   input  wire logic        motion_sense_input,   // Direction level, 1 = forward.
   input  wire logic        output_stage_allow_input, // High energises the motor unless a fault is latched.
   input  wire logic [7:0]  config_switch_bank,   // Switch bank, 1 = on.
   input  wire logic        fault_detect_input,   // Protection trip from power stage.
   // Drive and indicators.
   output logic             motor_energise,       // Power stage on.
   output logic             motor_direction,      // Direction of the last step.
   output logic [15:0]      microstep_position,   // Microstep position count.
   output logic [6:0]       current_command,      // Applied peak current, tenths of A.
   output logic [16:0]      steps_per_rev,        // Active resolution.
   output logic             self_test_start,      // One-cycle self-test trigger.
   output logic             red_led,              // Fault indicator.
   output logic             green_led,            // Power indicator.
   output logic             alarm_output_line_o,  // Alarm line drive level.
   output logic             alarm_output_line_oe_n, // Low while the alarm line is pulled.
   output logic             irq                   // Level interrupt.
);

   // --------------------------------------------------------------------------
   // Parameter checks
   // --------------------------------------------------------------------------
   if (STANDSTILL_CYCLES < 1 || TAP_WINDOW_CYCLES < 1) begin : g_chk
      $error("stdcc_top: delay counts must be at least one cycle");
   end

   // --------------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------------
   localparam stdcc_state_t RST_STATE = '{
      sw_cur:     `STDCC_CUR_RST,
      sw_res:     `STDCC_RES_RST,
      irq_stat:   3'h0,
      irq_mask:   3'h0,
      tap:        STDCC_TAP_IDLE,
      step_d:     1'b0,
      sel_d:      1'b0,
      fault:      1'b0,
      reduced:    1'b0,
      energ:      1'b0,
      dir:        1'b0,
      pos:        16'h0000,
      cur_out:    7'h00,
      spr:        17'h0_0000,
      test_pulse: 1'b0,
      alarm_oe:   1'b1,
      red:        1'b0,
      green:      1'b1,
      irq:        1'b0,
      dp_wr:      1'b0,
      dp_addr:    8'h00,
      rdata:      32'h0000_0000,
      hrdy:       1'b1
   };

   stdcc_state_t s_reg;
   stdcc_state_t s_next;

   // --------------------------------------------------------------------------
   // Configuration decode and timers
   // --------------------------------------------------------------------------
   logic [6:0]  dec_cur;
   logic [16:0] dec_spr;
   logic        cur_soft;
   logic        res_soft;
   logic        step_ok;
   logic        sel_change;
   logic        tap_restart;
   logic        still_expired;
   logic        tap_expired;

   // Decode runs on live switches; a switch change mid-motion is the
   // controller's problem, the drive follows it on the next cycle.
   stdcc_cfg_decode u_decode (
      .switches   (config_switch_bank),
      .soft_cur   (s_reg.sw_cur),
      .soft_res   (s_reg.sw_res),
      .cur_tenths (dec_cur),
      .steps_rev  (dec_spr),
      .cur_soft   (cur_soft),
      .res_soft   (res_soft)
   );

   // Standstill delay, restarted by every accepted step.
   stdcc_timer #(
      .COUNT (STANDSTILL_CYCLES)
   ) u_still (
      .clk     (clk),
      .rst     (rst),
      .restart (step_ok),
      .expired (still_expired)
   );

   // Window in which the second selector change must arrive.
   stdcc_timer #(
      .COUNT (TAP_WINDOW_CYCLES)
   ) u_tap (
      .clk     (clk),
      .rst     (rst),
      .restart (tap_restart),
      .expired (tap_expired)
   );

   // --------------------------------------------------------------------------
   // Event detection
   // --------------------------------------------------------------------------
   // A step is accepted only while the stage is allowed and no fault is latched.
   assign step_ok     = step_pulse_input && !s_reg.step_d
                        && output_stage_allow_input && !s_reg.fault;
   assign sel_change  = config_switch_bank[`STDCC_SW_SEL] != s_reg.sel_d;
   assign tap_restart = sel_change && (s_reg.tap == STDCC_TAP_IDLE);

   // --------------------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------------------
   logic [8:0]  cur_x3;
   logic [6:0]  cur_red;
   logic [2:0]  irq_ev;
   logic [2:0]  irq_clr;
   logic        take;
   logic        sel_on;

   always_comb begin
      s_next     = s_reg;
      irq_ev     = 3'h0;
      irq_clr    = 3'h0;
      sel_on     = config_switch_bank[`STDCC_SW_SEL];
      cur_x3     = 9'(dec_cur) * `STDCC_RED_NUM;
      cur_red    = 7'(cur_x3 / `STDCC_RED_DEN);
      take       = hsel && hready && htrans[1];

      // Input history for edge detection.
      s_next.step_d     = step_pulse_input;
      s_next.sel_d      = sel_on;
      s_next.test_pulse = 1'b0;

      // Position follows the direction level sampled at the step edge.
      if (step_ok) begin
         s_next.dir = motion_sense_input;
         if (motion_sense_input) begin
            s_next.pos = s_reg.pos + 16'h0001;
         end else begin
            s_next.pos = s_reg.pos - 16'h0001;
         end
      end

      // Reduction needs the switch on and the delay run out; a step ends it.
      s_next.reduced = sel_on && still_expired && !step_ok;
      if (s_next.reduced && !s_reg.reduced) begin
         irq_ev[`STDCC_IRQ_STANDSTILL] = 1'b1;
      end
      s_next.cur_out = s_next.reduced ? cur_red : dec_cur;
      s_next.spr     = dec_spr;

      // Two selector changes inside the window trigger the self-test.
      unique case (s_reg.tap)
         STDCC_TAP_IDLE: begin
            if (sel_change) begin
               s_next.tap = STDCC_TAP_ONE;
            end
         end
         STDCC_TAP_ONE: begin
            if (sel_change) begin
               s_next.tap        = STDCC_TAP_IDLE;
               s_next.test_pulse = 1'b1;
               irq_ev[`STDCC_IRQ_SELFTEST] = 1'b1;
            end else if (tap_expired) begin
               s_next.tap = STDCC_TAP_IDLE;
            end
         end
      endcase

      // The fault only ever sets; only reset clears it.
      if (fault_detect_input) begin
         s_next.fault = 1'b1;
      end
      if (s_next.fault && !s_reg.fault) begin
         irq_ev[`STDCC_IRQ_FAULT] = 1'b1;
      end
      s_next.energ    = output_stage_allow_input && !s_next.fault;
      s_next.red      = s_next.fault;
      s_next.alarm_oe = !s_next.fault;
      s_next.green    = 1'b1;

      // Data phase of a write.
      if (s_reg.dp_wr) begin
         unique case (s_reg.dp_addr)
            `STDCC_CTRL_OFS: begin
               s_next.sw_cur = hwdata[`STDCC_CTRL_CUR_LSB +: 7];
               s_next.sw_res = hwdata[`STDCC_CTRL_RES_LSB +: 10];
            end
            `STDCC_STATUS_OFS: begin
               irq_clr = hwdata[2:0];
            end
            `STDCC_MASK_OFS: begin
               s_next.irq_mask = hwdata[2:0];
            end
            default: begin
               irq_clr = 3'h0;
            end
         endcase
      end

      // Set wins over a clear landing in the same cycle.
      s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | irq_ev;
      s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

      // Address phase: latch write target, fetch read data for the data phase.
      s_next.dp_wr   = take && hwrite;
      s_next.dp_addr = haddr;
      s_next.rdata   = 32'h0000_0000;
      if (take && !hwrite) begin
         unique case (haddr)
            `STDCC_CTRL_OFS: begin
               s_next.rdata = {14'h0000, s_reg.sw_res, 1'b0, s_reg.sw_cur};
            end
            `STDCC_STATUS_OFS: begin
               s_next.rdata = {29'h0000_0000, s_reg.irq_stat};
            end
            `STDCC_MASK_OFS: begin
               s_next.rdata = {29'h0000_0000, s_reg.irq_mask};
            end
            `STDCC_STATE_OFS: begin
               s_next.rdata = {12'h000, config_switch_bank, res_soft, cur_soft,
                               s_reg.energ, s_reg.fault, s_reg.reduced, s_reg.cur_out};
            end
            `STDCC_POS_OFS: begin
               s_next.rdata = {16'h0000, s_reg.pos};
            end
            `STDCC_SPR_OFS: begin
               s_next.rdata = {15'h0000, s_reg.spr};
            end
            default: begin
               s_next.rdata = 32'h0000_0000;
            end
         endcase
      end
      s_next.hrdy = 1'b1;
   end

   // --------------------------------------------------------------------------
   // State register
   // --------------------------------------------------------------------------
   // All state except the two timers lives in one register so that reset covers it at once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   // Outputs other than hresp and the alarm level are register fields; the alarm level is a constant low so the
   // enable alone decides whether the open-collector line is pulled.
   assign hreadyout              = s_reg.hrdy;
   assign hresp                  = 1'b0;
   assign hrdata                 = s_reg.rdata;
   assign motor_energise         = s_reg.energ;
   assign motor_direction        = s_reg.dir;
   assign microstep_position     = s_reg.pos;
   assign current_command        = s_reg.cur_out;
   assign steps_per_rev          = s_reg.spr;
   assign self_test_start        = s_reg.test_pulse;
   assign red_led                = s_reg.red;
   assign green_led              = s_reg.green;
   assign alarm_output_line_o    = 1'b0;
   assign alarm_output_line_oe_n = s_reg.alarm_oe;
   assign irq                    = s_reg.irq;

endmodule

//--- dv/stdcc_ctrl_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Motion controller model: step pulses with a direction level.
// ---------------------------------------------------------------
module stdcc_ctrl_model (
   input  wire logic clk,                // System clock.
   output logic      step_pulse_input,   // Step pulse, rising edge active.
   output logic      motion_sense_input  // Direction level, 1 = forward.
);
   // Idle with the step line low so no edge is seen after reset.
   initial begin
      step_pulse_input = 1'b0;
      motion_sense_input = 1'b1;
   end
   // Direction is set with the rising step and held through the low phase.
   // A gap of zero still leaves one low cycle, the tightest legal spacing.
   task automatic pulse(input logic fwd, input int n, input int gap);
      repeat (n) begin
         @(posedge clk);
         step_pulse_input <= 1'b1;
         motion_sense_input <= fwd;
         @(posedge clk);
         step_pulse_input <= 1'b0;
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule

//--- dv/stdcc_top_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker for the drive command block.
// ---------------------------------------------------------------
module stdcc_top_assertions #(
   parameter int STANDSTILL_CYCLES = 20,
   parameter int TAP_WINDOW_CYCLES = 50
) (
   input wire logic        clk,                      // Clock.
   input wire logic        rst,                      // Reset.
   input wire logic        step_pulse_input,         // Step.
   input wire logic        motion_sense_input,       // Direction.
   input wire logic        output_stage_allow_input, // Enable.
   input wire logic [7:0]  config_switch_bank,       // Switches.
   input wire logic        fault_detect_input,       // Trip.
   input wire logic        motor_energise,           // Power stage.
   input wire logic [15:0] microstep_position,       // Position.
   input wire logic [6:0]  current_command,          // Current.
   input wire logic        self_test_start,          // Self-test.
   input wire logic        red_led,                  // Fault lamp.
   input wire logic        green_led,                // Power lamp.
   input wire logic        alarm_output_line_oe_n    // Alarm drive.
);
   // Slack around the delay, since the exact restart edge is a design choice.
   localparam int SS_LO = STANDSTILL_CYCLES - 2;
   localparam int SS_HI = STANDSTILL_CYCLES + 4;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // An accepted step: fresh rising edge, stage allowed, no fault.
   sequence s_step;
      $rose(step_pulse_input) && output_stage_allow_input && !red_led && !fault_detect_input;
   endsequence
   AST_GREEN:
      assert property (green_led) else $error("power lamp dark");
   AST_FAULT:
      assert property (fault_detect_input |=> red_led && !alarm_output_line_oe_n
         && !motor_energise) else $error("fault not shown");
   AST_LATCH:
      assert property (red_led |=> red_led && !alarm_output_line_oe_n) else $error("fault lost");
   AST_ENA:
      assert property (output_stage_allow_input && !red_led && !fault_detect_input
         |=> motor_energise) else $error("stage not energised");
   AST_OFF:
      assert property (!output_stage_allow_input |=> !motor_energise) else $error("stage on");
   AST_STEP:
      assert property (s_step |=> microstep_position == $past(microstep_position)
         + ($past(motion_sense_input) ? 16'h0001 : 16'hFFFF)) else $error("bad step count");
   AST_HOLD:
      assert property (!$rose(step_pulse_input) |=> $stable(microstep_position))
         else $error("position moved");
   AST_REFUSE:
      assert property (!output_stage_allow_input |=> $stable(microstep_position))
         else $error("step while disabled");
   AST_FULL:
      assert property (s_step ##0 config_switch_bank[2:0] == 3'b111
         |=> current_command == 7'h52) else $error("current not restored");
   AST_REDUCE:
      assert property (s_step ##0 config_switch_bank[3:0] == 4'hF
         |=> ##[SS_LO:SS_HI] current_command == 7'h31) else $error("no reduction");
   AST_TEST:
      assert property (self_test_start |-> $past(config_switch_bank[3], 1)
         != $past(config_switch_bank[3], 2) || $past(config_switch_bank[3], 2)
         != $past(config_switch_bank[3], 3) || $past(config_switch_bank[3], 3)
         != $past(config_switch_bank[3], 4)) else $error("self-test without toggle");
   COV_STEP: cover property (s_step);
   COV_TEST: cover property (self_test_start);
   COV_FAULT: cover property ($rose(red_led));
endmodule

bind stdcc_top stdcc_top_assertions #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES),
   .TAP_WINDOW_CYCLES(TAP_WINDOW_CYCLES)) u_stdcc_top_assertions (.*);

//--- dv/stdcc_top_bench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the drive command block.
// ---------------------------------------------------------------
module stdcc_top_bench;
   logic        clk, rst, hsel, hwrite, output_stage_allow_input, fault_detect_input;
   logic        hreadyout, hresp, step_pulse_input, motion_sense_input, motor_energise;
   logic        motor_direction, self_test_start, red_led, green_led, irq;
   logic        alarm_output_line_o, alarm_output_line_oe_n;
   logic [7:0]  haddr, config_switch_bank;
   logic [1:0]  htrans;
   logic [2:0]  hsize, idx;
   logic [31:0] hwdata, hrdata, rd;
   logic [15:0] microstep_position;
   logic [6:0]  current_command;
   logic [16:0] steps_per_rev;
   int          bad_count, checks_done, k, e;
   int          res_tbl[8] = '{1000, 2000, 4000, 5000, 8000, 10000, 20000, 25000};
   int          cur_tbl[8] = '{0, 22, 32, 45, 52, 63, 72, 82};

   stdcc_top #(.STANDSTILL_CYCLES(20), .TAP_WINDOW_CYCLES(50)) u_stdcc_top (
      .hready(hreadyout), .*);
   stdcc_ctrl_model u_stdcc_ctrl_model (.clk(clk), .step_pulse_input(step_pulse_input),
      .motion_sense_input(motion_sense_input));

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // One single word transfer; both phases wait on ready, no wait count is assumed.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(negedge clk); while (hreadyout !== 1'b1);
      @(posedge clk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(negedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      @(posedge clk);
   endtask
   // Waits whole cycles, then settles mid-cycle where outputs are stable.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
      checks_done++;
      if (g !== ex) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, ex, g);
      end
   endtask
   task automatic end_sim;
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog at many times the expected run length.
   initial begin
      #1_000_000;
      bad_count++;
      end_sim();
   end
   // Main sequence; switches never move while pulses are running.
   initial begin
      rst = 1'b1;
      {hsel, haddr, htrans, hwrite, hwdata, fault_detect_input} = '0;
      hsize = 3'b010;
      output_stage_allow_input = 1'b1;
      config_switch_bank = 8'hF0;
      bad_count = 0;
      checks_done = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      chk("green", 1, 32'(green_led));
      chk("alarm", 1, 32'(alarm_output_line_oe_n));
      bus(1'b0, 8'h00, 0);
      chk("ctrl", 32'h0000_0105, rd);
      bus(1'b1, 8'h00, 32'h0000_0414);
      bus(1'b0, 8'h1C, 0);
      chk("unmapped", 0, rd);
      chk("hresp", 0, 32'(hresp));
      cyc(2);
      chk("softcur", 32'h0000_0014, 32'(current_command));
      chk("softres", 800, 32'(steps_per_rev));
      bus(1'b0, 8'h14, 0);
      chk("sprreg", 800, rd);
      for (k = 1; k < 8; k++) begin
         @(posedge clk);
         config_switch_bank <= {5'h1E, k[2:0]};
         cyc(3);
         chk("cur", cur_tbl[k], 32'(current_command));
      end
      for (k = 0; k < 15; k++) begin
         @(posedge clk);
         config_switch_bank <= {k[3:0], 4'h1};
         idx = ~k[2:0];
         e = k[3] ? (400 << (idx - 1)) : res_tbl[idx];
         cyc(3);
         chk("spr", e, 32'(steps_per_rev));
      end
      u_stdcc_ctrl_model.pulse(1'b1, 5, 0);
      u_stdcc_ctrl_model.pulse(1'b0, 2, 3);
      cyc(2);
      chk("pos", 3, 32'(microstep_position));
      chk("dir", 0, 32'(motor_direction));
      @(posedge clk) output_stage_allow_input <= 1'b0;
      u_stdcc_ctrl_model.pulse(1'b1, 2, 1);
      cyc(2);
      chk("energise", 0, 32'(motor_energise));
      @(posedge clk) output_stage_allow_input <= 1'b1;
      bus(1'b0, 8'h10, 0);
      chk("posreg", 3, rd);
      @(posedge clk);
      config_switch_bank <= 8'h0F;
      u_stdcc_ctrl_model.pulse(1'b1, 1, 0);
      cyc(1);
      chk("full", 32'h0000_0052, 32'(current_command));
      cyc(25);
      chk("reduced", 32'h0000_0031, 32'(current_command));
      bus(1'b0, 8'h04, 0);
      chk("status", 32'h0000_0004, rd);
      chk("irqmask", 0, 32'(irq));
      bus(1'b1, 8'h08, 32'h0000_0004);
      cyc(1);
      chk("irqon", 1, 32'(irq));
      bus(1'b1, 8'h04, 32'h0000_0004);
      cyc(1);
      chk("irqoff", 0, 32'(irq));
      cyc(40);
      @(posedge clk) config_switch_bank <= 8'h07;
      cyc(5);
      @(posedge clk) config_switch_bank <= 8'h0F;
      for (k = 0; k < 10 && self_test_start !== 1'b1; k++) @(negedge clk);
      chk("selftest", 1, 32'(self_test_start));
      bus(1'b0, 8'h04, 0);
      chk("teststat", 1, 32'(rd[1]));
      @(posedge clk);
      fault_detect_input <= 1'b1;
      @(posedge clk);
      fault_detect_input <= 1'b0;
      bus(1'b1, 8'h04, 32'h0000_0001);
      cyc(3);
      chk("red", 1, 32'(red_led));
      chk("oe", 0, {alarm_output_line_o, alarm_output_line_oe_n});
      u_stdcc_ctrl_model.pulse(1'b1, 2, 0);
      cyc(2);
      chk("frozen", 4, 32'(microstep_position));
      chk("free", 0, 32'(motor_energise));
      end_sim();
   end
endmodule
